// [tb/fdpc_core_model.sv]
// Purpose: core model issuing register reads and writes
// Assumes: strobes launched by non-blocking assignment at the rising edge
// Notes: released address and data lines show the inverse of the last value
`default_nettype none
module fdpc_core_model (
   input wire logic clock_i,
   input wire logic stall_i,
   input wire logic [7:0] rdata_i,
   output logic wr_o,
   output logic rd_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      wr_o <= 1'b1;
      addr_o <= a;
      wdata_o <= d;
      @(posedge clock_i);
      wr_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock_i);
      rd_o <= 1'b1;
      addr_o <= a;
      @(posedge clock_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
      #1;
      d = rdata_i;
   endtask
   task automatic idle();
      int n;
      n = 0;
      repeat (2) @(posedge clock_i);
      #1;
      while (stall_i && n < 1000)
      begin
         @(posedge clock_i);
         #1;
         n++;
      end
   endtask
endmodule // fdpc_core_model
`default_nettype wire

// [tb/fdpc_props.sv]
// Purpose: port assertions for the data page controller
// Assumes: timing word 0001 and small tick counts in sim
// Notes: page register is shadowed from observed writes
`default_nettype none
`include "fdpc_defines.svh"
module fdpc_props
   import fdpc_pkg::*;
(
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic [7:0] sfr_rdata_o,
   input wire logic sfr_hit_o,
   input wire logic core_stall_o,
   input wire logic irq_hold_o
);
   logic [7:0] pg_q;
   logic cw;
   logic slow;
   logic fast;
   logic mapped;
   assign cw = sfr_wr_i && !core_stall_o && sfr_addr_i == `FDPC_ADDR_CMD;
   assign slow = sfr_wdata_i == `FDPC_CMD_ERASE_ALL || (pg_q <= `FDPC_LAST_PAGE &&
      sfr_wdata_i inside {`FDPC_CMD_PROG, `FDPC_CMD_ERASE});
   assign fast = sfr_wdata_i inside {`FDPC_CMD_READ, `FDPC_CMD_VERIFY};
   assign mapped = sfr_addr_i inside {[8'hB9:8'hBF], 8'hC4, 8'hC6};
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         pg_q <= 8'h00;
      else if (sfr_wr_i && !core_stall_o && sfr_addr_i == `FDPC_ADDR_PAGE)
         pg_q <= sfr_wdata_i;
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (srst_i);
   sequence s_slow_cmd;
      cw && slow;
   endsequence
   sequence s_held;
      core_stall_o [*2];
   endsequence
   a_slow_stalls: assert property (s_slow_cmd |=> s_held)
      else $error("long command did not stall");
   a_fast_no_stall: assert property (cw && fast |=> !core_stall_o [*2])
      else $error("read or verify stalled");
   a_ignore_rsvd: assert property (cw && !slow && !fast |=> !core_stall_o [*2])
      else $error("ignored command stalled");
   a_irq_follows: assert property (irq_hold_o == core_stall_o)
      else $error("interrupt hold differs from stall");
   a_stall_ends: assert property ($rose(core_stall_o) |-> ##[2:400] !core_stall_o)
      else $error("stall length out of range");
   a_stall_cause: assert property ($rose(core_stall_o) |-> $past(cw))
      else $error("stall without command write");
   a_hit_mapped: assert property (sfr_rd_i && mapped |=> sfr_hit_o)
      else $error("mapped read gave no hit");
   a_unmapped_zero: assert property (sfr_rd_i && !mapped |=> !sfr_hit_o && sfr_rdata_o == 8'h00)
      else $error("unmapped read not zero");
endmodule // fdpc_props
bind fdpc_ctrl fdpc_props fdpc_props_inst (.clock_i(clock_i), .srst_i(srst_i),
   .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_addr_i(sfr_addr_i),
   .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o),
   .core_stall_o(core_stall_o), .irq_hold_o(irq_hold_o));
`default_nettype wire

// [tb/tb.sv]
// Purpose: self-checking bench for the data page controller
// Assumes: timing word set to 0001, erase ticks cut to 2
// Notes: array model starts erased, as the simulated array does
`default_nettype none
`include "fdpc_defines.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i = 1'b0;
   logic srst_i = 1'b1;
   logic wr, rd, hit, stall, irq;
   logic [7:0] addr, wdata, rdata, b, p;
   logic [31:0] w, d;
   logic [31:0] mem [160];
   int n_mismatch = 0;
   int check_count = 0;
   logic [7:0] ra [10] = '{8'hBC, 8'hBD, 8'hBE, 8'hBF, 8'hC6, 8'hB9, 8'hBA, 8'hBB, 8'hC4, 8'h80};
   logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h50, 8'h04, 8'hC9, 8'h00};
   logic [7:0] rc [5] = '{8'h00, 8'h07, 8'h80, 8'hFF, `FDPC_CMD_ERASE};
   always #12.5 clock_i = ~clock_i;
   fdpc_ctrl #(.ERASE_TICKS(16'h0002)) fdpc_ctrl_inst (.clock_i(clock_i), .srst_i(srst_i),
      .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_addr_i(addr), .sfr_wdata_i(wdata),
      .sfr_rdata_o(rdata), .sfr_hit_o(hit), .core_stall_o(stall), .irq_hold_o(irq));
   fdpc_core_model fdpc_core_model_inst (.clock_i(clock_i), .stall_i(stall), .rdata_i(rdata),
      .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
   function automatic logic [7:0] vfy_exp(input logic [31:0] a, input logic [31:0] s);
      return (a === s) ? 8'h00 : `FDPC_VERIFY_FAIL;
   endfunction
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] v);
      fdpc_core_model_inst.wr(a, v);
   endtask
   task automatic rreg(input logic [7:0] a, output logic [7:0] v);
      fdpc_core_model_inst.rd(a, v);
   endtask
   task automatic cmd(input logic [7:0] pg, input logic [7:0] c);
      wreg(8'hC6, pg);
      wreg(8'hB9, c);
      fdpc_core_model_inst.idle();
   endtask
   task automatic put(input logic [31:0] v);
      for (int i = 0; i < 4; i++)
         wreg(8'hBC + 8'(i), v[8*i +: 8]);
   endtask
   task automatic get(input logic [7:0] pg, output logic [31:0] v);
      logic [7:0] t;
      cmd(pg, `FDPC_CMD_READ);
      for (int i = 0; i < 4; i++)
      begin
         rreg(8'hBC + 8'(i), t);
         v[8*i +: 8] = t;
      end
   endtask
   task automatic results();
      if (n_mismatch == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      #(40000 * 25);
      n_mismatch++;
      results();
   end
   initial
   begin
      void'($urandom(94303));
      foreach (mem[i])
         mem[i] = 32'hFFFFFFFF;
      repeat (5) @(posedge clock_i);
      srst_i <= 1'b0;
      foreach (ra[i])
      begin
         rreg(ra[i], b);
         chk("reset value", rv[i], b);
         chk("read hit", 32'(ra[i] != 8'h80), hit);
      end
      wreg(8'hBA, 8'h01);
      wreg(8'hBB, 8'h00);
      cmd(8'hA5, `FDPC_CMD_ERASE_ALL);
      for (int k = 0; k < 8; k++)
      begin
         p = (k == 0) ? 8'h00 : (k == 1) ? `FDPC_LAST_PAGE : 8'($urandom_range(159));
         w = $urandom;
         put(w);
         // a data write landing in the erase stall must be dropped
         wreg(8'hC6, p);
         wreg(8'hB9, `FDPC_CMD_ERASE);
         wreg(8'hBC, ~w[7:0]);
         #1;
         chk("erase stall", 1'b1, stall);
         chk("erase irq hold", 1'b1, irq);
         fdpc_core_model_inst.idle();
         cmd(p, `FDPC_CMD_PROG);
         mem[p] = w;
         put(32'h0);
         get(p, d);
         chk("page read", mem[p], d);
         for (int j = 0; j < 2; j++)
         begin
            put(w ^ (32'(j) << 16));
            cmd(p, `FDPC_CMD_VERIFY);
            rreg(8'hB9, b);
            chk("verify", vfy_exp(mem[p], w ^ (32'(j) << 16)), b);
         end
      end
      cmd(p, `FDPC_CMD_ERASE);
      mem[p] = 32'hFFFFFFFF;
      // change one byte of a page and keep the other three
      get(8'h03, d);
      wreg(8'hBD, 8'hF3);
      cmd(8'h03, `FDPC_CMD_ERASE);
      cmd(8'h03, `FDPC_CMD_PROG);
      mem[3][15:8] = 8'hF3;
      foreach (rc[i])
      begin
         if (i == 4)
            wreg(8'hC6, 8'hA0);
         wreg(8'hB9, rc[i]);
         @(posedge clock_i);
         #1;
         chk("no stall", 1'b0, stall);
         chk("no irq hold", 1'b0, irq);
         rreg(8'hB9, b);
         chk("command echo", rc[i], b);
      end
      for (int k = 0; k < 160; k++)
      begin
         get(8'(k), d);
         chk("array scan", mem[k], d);
      end
      results();
   end
endmodule // tb
`default_nettype wire

// [verilog/fdpc_array.sv]
// Purpose: nonvolatile page array model, one 32-bit word per page
// Assumes: single port, registered read data
// Notes: array contents survive srst_i as a nonvolatile array would
`default_nettype none
`include "fdpc_defines.svh"
module fdpc_array
   import fdpc_pkg::*;
#(
   parameter int PAGES = 160
)(
   input wire logic clock_i,
   input wire fdpc_mem_req_t req_i,
   output logic [31:0] rdata_o
);
   logic [31:0] mem [PAGES];
   // delivered erased
   initial
   begin
      for (int i = 0; i < PAGES; i++)
      begin
         mem[i] = {4{`FDPC_ERASED}};
      end
   end
   always_ff @(posedge clock_i)
   begin
      if (req_i.we)
      begin
         mem[req_i.page] <= req_i.wdata;
      end
      rdata_o <= mem[req_i.page];
   end
endmodule // fdpc_array
`default_nettype wire

// [verilog/fdpc_ctrl.sv]
// Purpose: special function register controller for a 640-byte data page array
// Assumes: byte register port from the core, one 40 MHz clock
// Notes: core_stall_o holds the core; timers elsewhere keep running
`default_nettype none
`include "fdpc_defines.svh"
module fdpc_ctrl
   import fdpc_pkg::*;
#(
   parameter int PAGES = 160,
   parameter logic [15:0] PROG_TICKS = `FDPC_PROG_TICKS,
   parameter logic [15:0] ERASE_TICKS = `FDPC_ERASE_TICKS
)(
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_wdata_i,
   output logic [7:0] sfr_rdata_o,
   output logic sfr_hit_o,
   output logic core_stall_o,
   output logic irq_hold_o
);
   // ==========================================
   // registers
   logic [7:0] data_q [4];
   logic [7:0] page_q;
   logic [7:0] cmd_q;
   logic [7:0] tim1_q, tim2_q, tim3_q;
   logic [7:0] op_q;
   logic [7:0] op_page_q;
   fdpc_state_t state_q;
   logic [15:0] div_q;
   logic [15:0] ticks_q;
   logic tick_en;
   logic [31:0] rdata;
   fdpc_mem_req_t req;
   logic cmd_wr;
   logic cmd_ok;

   function automatic logic is_page_cmd(input logic [7:0] c);
      return c == `FDPC_CMD_READ || c == `FDPC_CMD_PROG || c == `FDPC_CMD_VERIFY
         || c == `FDPC_CMD_ERASE;
   endfunction

   // only timed commands hold the core; read and verify finish in two cycles
   function automatic logic is_slow_cmd(input logic [7:0] c);
      return c == `FDPC_CMD_PROG || c == `FDPC_CMD_ERASE || c == `FDPC_CMD_ERASE_ALL;
   endfunction

   function automatic logic [31:0] data_word(input logic [7:0] d [4]);
      return {d[3], d[2], d[1], d[0]};
   endfunction

   assign cmd_wr = sfr_wr_i && sfr_addr_i == `FDPC_ADDR_CMD && state_q == ST_IDLE;
   assign cmd_ok = (is_page_cmd(sfr_wdata_i) && page_q <= `FDPC_LAST_PAGE)
      || sfr_wdata_i == `FDPC_CMD_ERASE_ALL;

   // ==========================================
   // array port
   always_comb
   begin
      req.we = 1'b0;
      req.page = (state_q == ST_IDLE) ? page_q : op_page_q;
      req.wdata = {4{`FDPC_ERASED}};
      if (state_q == ST_WRITE)
      begin
         req.we = 1'b1;
         req.wdata = (op_q == `FDPC_CMD_PROG) ? data_word(data_q) : {4{`FDPC_ERASED}};
      end
      else if (state_q == ST_ERASE_ALL)
      begin
         req.we = 1'b1;
      end
   end

   fdpc_array #(
      .PAGES(PAGES)
   ) u_array (
      .clock_i(clock_i),
      .req_i(req),
      .rdata_o(rdata)
   );

   // ==========================================
   // tick divider from the timing word
   // clock derived tick
   always_ff @(posedge clock_i)
   begin
      if (srst_i || state_q != ST_WAIT)
      begin
         div_q <= 16'h0000;
      end
      else if (div_q + 16'h0001 >= {tim2_q, tim1_q})
      begin
         div_q <= 16'h0000;
      end
      else
      begin
         div_q <= div_q + 16'h0001;
      end
   end
   assign tick_en = state_q == ST_WAIT && div_q + 16'h0001 >= {tim2_q, tim1_q};

   // ==========================================
   // operation sequencer
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         state_q <= ST_IDLE;
         op_q <= `FDPC_RST_BYTE;
         op_page_q <= `FDPC_RST_BYTE;
         ticks_q <= 16'h0000;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               if (cmd_wr && cmd_ok)
               begin
                  op_q <= sfr_wdata_i;
                  op_page_q <= (sfr_wdata_i == `FDPC_CMD_ERASE_ALL) ? 8'h00 : page_q;
                  ticks_q <= (sfr_wdata_i == `FDPC_CMD_PROG) ? PROG_TICKS : ERASE_TICKS;
                  if (sfr_wdata_i == `FDPC_CMD_ERASE_ALL)
                  begin
                     state_q <= ST_ERASE_ALL;
                  end
                  else if (sfr_wdata_i == `FDPC_CMD_PROG || sfr_wdata_i == `FDPC_CMD_ERASE)
                  begin
                     state_q <= ST_WAIT;
                  end
                  else
                  begin
                     state_q <= ST_DONE;
                  end
               end
            end
            ST_ERASE_ALL:
            begin
               if (op_page_q == `FDPC_LAST_PAGE)
               begin
                  op_page_q <= 8'h00;
                  state_q <= ST_WAIT;
               end
               else
               begin
                  op_page_q <= op_page_q + 8'h01;
               end
            end
            ST_WAIT:
            begin
               if (tick_en)
               begin
                  if (ticks_q <= 16'h0001)
                  begin
                     state_q <= (op_q == `FDPC_CMD_ERASE_ALL) ? ST_IDLE : ST_WRITE;
                  end
                  ticks_q <= ticks_q - 16'h0001;
               end
            end
            ST_WRITE:
            begin
               state_q <= ST_IDLE;
            end
            ST_DONE:
            begin
               state_q <= ST_IDLE;
            end
            default:
            begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================
   // software registers
   // page address and timing registers
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         page_q <= `FDPC_RST_BYTE;
         tim1_q <= 8'(`FDPC_RST_TIM_WORD);
         tim2_q <= 8'(`FDPC_RST_TIM_WORD >> 8);
         tim3_q <= `FDPC_RST_TIM3;
      end
      else if (sfr_wr_i && state_q == ST_IDLE)
      begin
         case (sfr_addr_i)
            `FDPC_ADDR_PAGE: page_q <= sfr_wdata_i;
            `FDPC_ADDR_TIM1: tim1_q <= sfr_wdata_i;
            `FDPC_ADDR_TIM2: tim2_q <= sfr_wdata_i;
            `FDPC_ADDR_TIM3: tim3_q <= sfr_wdata_i;
            default:
            begin
            end
         endcase
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         for (int i = 0; i < 4; i++)
         begin
            data_q[i] <= `FDPC_RST_BYTE;
         end
      end
      else if (state_q == ST_DONE && op_q == `FDPC_CMD_READ)
      begin
         for (int i = 0; i < 4; i++)
         begin
            data_q[i] <= rdata[8*i +: 8];
         end
      end
      else if (sfr_wr_i && state_q == ST_IDLE && sfr_addr_i >= `FDPC_ADDR_DATA1
         && sfr_addr_i <= `FDPC_ADDR_DATA4)
      begin
         data_q[2'(sfr_addr_i - `FDPC_ADDR_DATA1)] <= sfr_wdata_i;
      end
   end

   // command register holds last code, or verify result
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         cmd_q <= `FDPC_RST_BYTE;
      end
      else if (state_q == ST_DONE && op_q == `FDPC_CMD_VERIFY)
      begin
         cmd_q <= (rdata == data_word(data_q)) ? 8'h00 : `FDPC_VERIFY_FAIL;
      end
      else if (cmd_wr)
      begin
         cmd_q <= sfr_wdata_i;
      end
   end

   // ==========================================
   // outputs
   // stall core and hold interrupts
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         core_stall_o <= 1'b0;
         irq_hold_o <= 1'b0;
      end
      else
      begin
         core_stall_o <= (cmd_wr && cmd_ok && is_slow_cmd(sfr_wdata_i))
            || state_q == ST_ERASE_ALL || state_q == ST_WAIT;
         irq_hold_o <= (cmd_wr && cmd_ok && is_slow_cmd(sfr_wdata_i))
            || state_q == ST_ERASE_ALL || state_q == ST_WAIT;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         sfr_rdata_o <= 8'h00;
         sfr_hit_o <= 1'b0;
      end
      else
      begin
         sfr_hit_o <= sfr_rd_i;
         case (sfr_addr_i)
            `FDPC_ADDR_DATA1: sfr_rdata_o <= data_q[0];
            `FDPC_ADDR_DATA2: sfr_rdata_o <= data_q[1];
            `FDPC_ADDR_DATA3: sfr_rdata_o <= data_q[2];
            `FDPC_ADDR_DATA4: sfr_rdata_o <= data_q[3];
            `FDPC_ADDR_PAGE: sfr_rdata_o <= page_q;
            `FDPC_ADDR_CMD: sfr_rdata_o <= cmd_q;
            `FDPC_ADDR_TIM1: sfr_rdata_o <= tim1_q;
            `FDPC_ADDR_TIM2: sfr_rdata_o <= tim2_q;
            `FDPC_ADDR_TIM3: sfr_rdata_o <= tim3_q;
            default:
            begin
               sfr_rdata_o <= 8'h00;
               sfr_hit_o <= 1'b0;
            end
         endcase
      end
   end
endmodule // fdpc_ctrl
`default_nettype wire

// [verilog/fdpc_defines.svh]
// Purpose: constants for the data page controller
// Assumes: 40 MHz master clock, byte-wide register port
// Notes: register addresses are special function register addresses
`ifndef FDPC_DEFINES_SVH
`define FDPC_DEFINES_SVH
// ==========================================
// register addresses
`define FDPC_ADDR_DATA1 8'hBC
`define FDPC_ADDR_DATA2 8'hBD
`define FDPC_ADDR_DATA3 8'hBE
`define FDPC_ADDR_DATA4 8'hBF
`define FDPC_ADDR_PAGE 8'hC6
`define FDPC_ADDR_CMD 8'hB9
`define FDPC_ADDR_TIM1 8'hBA
`define FDPC_ADDR_TIM2 8'hBB
`define FDPC_ADDR_TIM3 8'hC4
// ==========================================
// command codes
`define FDPC_CMD_READ 8'h01
`define FDPC_CMD_PROG 8'h02
`define FDPC_CMD_VERIFY 8'h04
`define FDPC_CMD_ERASE 8'h05
`define FDPC_CMD_ERASE_ALL 8'h06
// ==========================================
// reset values and array geometry
`define FDPC_RST_BYTE 8'h00
`define FDPC_RST_TIM_WORD 16'h0450
`define FDPC_RST_TIM3 8'hC9
`define FDPC_ERASED 8'hFF
`define FDPC_LAST_PAGE 8'h9F
`define FDPC_VERIFY_FAIL 8'h01
// ==========================================
// timing: one tick is 100 us when the timing word is set right
`define FDPC_PROG_TICKS 16'h0003
`define FDPC_ERASE_TICKS 16'h00C8
`define FDPC_TICK_US 100
`define FDPC_CLK_MHZ 40
`define FDPC_TICK_CYCLES (`FDPC_TICK_US * `FDPC_CLK_MHZ)
`endif

// [verilog/fdpc_pkg.sv]
// Purpose: types for the data page controller
// Assumes: nothing
// Notes: none
`default_nettype none
package fdpc_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_ERASE_ALL, ST_WAIT, ST_WRITE, ST_DONE} fdpc_state_t;
   typedef struct packed {
      logic we;
      logic [7:0] page;
      logic [31:0] wdata;
   } fdpc_mem_req_t;
endpackage
`default_nettype wire
